// file: core/burst_sequencer.sv
/*
 * Two-bit burst sequencer: interleaved or linear order.
 * Assumes load and advance are never high together.
 */
`timescale 1ns/1ps
module burst_sequencer (
	input wire logic      clk,
	input wire logic      arst_n,
	input wire logic      clk_en,
	burst_step_if.cnt     bus
);
	import sram_port_pkg::*;

	burst_bits_t base_q;
	burst_bits_t base_d;
	burst_bits_t count_q;
	burst_bits_t count_d;
	burst_bits_t count_nx;

	//////////////////////////////////////////////////////////////////////
	// Next state: the count is kept apart from the start value so that
	// either order is a simple function of the pair
	always_comb begin
		base_d  = base_q;
		count_d = count_q;
		if (bus.load) begin
			base_d  = bus.start_bits;
			count_d = BURST_ZERO;
		end else if (bus.advance) begin
			count_d = count_nx;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base_q  <= BURST_ZERO;
			count_q <= BURST_ZERO;
		end else if (clk_en) begin
			base_q  <= base_d;
			count_q <= count_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Following address; the count wraps 11 to 00 by its width
	always_comb begin
		count_nx = burst_bits_t'(count_q + BURST_STEP);
		if (bus.interleave)
			bus.next_bits = base_q ^ count_nx;
		else
			bus.next_bits = burst_bits_t'(base_q + count_nx);
	end

endmodule : burst_sequencer

// file: core/burst_step_if.sv
/*
 * Carrier between the port control and its burst counter.
 * Assumes both ends share SYS_CLK.
 */
`timescale 1ns/1ps
interface burst_step_if;
	import sram_port_pkg::*;

	logic        load;
	logic        advance;
	logic        interleave;
	burst_bits_t start_bits;
	burst_bits_t next_bits;

	modport ctrl (
		output load,
		output advance,
		output interleave,
		output start_bits,
		input  next_bits
	);

	modport cnt (
		input  load,
		input  advance,
		input  interleave,
		input  start_bits,
		output next_bits
	);

endinterface : burst_step_if

// file: core/pipelined_burst_sram_port.sv
/*
 * Pipelined burst synchronous SRAM port with its storage array.
 * Assumes every input except OUTPUT_ENABLE_N, BURST_ORDER_SEL_N and
 * SNOOZE_REQ is synchronous to SYS_CLK; the data pin is split into
 * in, out and enable, resolved outside.
 */
`timescale 1ns/1ps

// Functional notes
// - Register all inputs except enable, order, snooze
// - Load address only when selected and strobed
// - Drive data only for reads with enable low
// - Master enable blocks processor strobe, not controller
// - Secondary enables: one high-active, one low-active
// - Either strobe loads address or deselects
// - Low advance steps the burst address
// - Global write writes all eighteen bits
// - Byte gate writes lanes whose strobe low
// - Both write enables high means read
// - Outputs high impedance on writes and deselect
// - High or floating order selects interleaved
// - Low order selects linear, wrapping modulo four
// - Snooze deselects and retains data while high
// - Snooze ignores inputs, outputs high impedance
// - Unconnected snooze input reads as low
// - Read data appears one edge later
// - Advance ignored on strobe edges
// - Controller strobe needs processor strobe high or master enable high
module pipelined_burst_sram_port #(
	parameter int ADDR_W = sram_port_pkg::ADDR_W
) (
	input  wire logic                      SYS_CLK,
	input  wire logic                      ARST_N,
	input  wire logic                      CLK_EN,
	input  wire logic [ADDR_W-1:0]         ADDR,
	input  wire sram_port_pkg::word_t      DQ_IN,
	output      sram_port_pkg::word_t      DQ_OUT,
	output      logic                      DQ_OE,
	input  wire logic                      MASTER_SELECT_N,
	input  wire logic                      SELECT_HI,
	input  wire logic                      SELECT_LO_N,
	input  wire logic                      PROC_ADDR_STROBE_N,
	input  wire logic                      CTRL_ADDR_STROBE_N,
	input  wire logic                      BURST_ADVANCE_N,
	input  wire logic                      GLOBAL_WRITE_N,
	input  wire logic                      BYTE_WRITE_GATE_N,
	input  wire sram_port_pkg::lane_mask_t BYTE_LANE_WRITE_N,
	input  wire logic                      OUTPUT_ENABLE_N,
	input  wire logic                      BURST_ORDER_SEL_N,
	input  wire logic                      SNOOZE_REQ
);
	import sram_port_pkg::*;

	localparam int WORDS = 2 ** ADDR_W;

	// The burst counter owns the two low bits; refused at elaboration
	if (ADDR_W <= BURST_W || ADDR_W > 24) begin : g_bad_width
		$error("ADDR_W must be 3 to 24");
	end

	//////////////////////////////////////////////////////////////////////
	// Declarations

	word_t              mem [WORDS];
	logic  [ADDR_W-1:0] addr_q;
	logic  [ADDR_W-1:0] addr_d;
	cycle_t             mode_q;
	cycle_t             mode_d;
	logic               rd_pend_q;
	logic               rd_pend_d;
	logic  [1:0]        hold_q;
	logic  [1:0]        hold_d;
	logic               drive_q;
	logic               drive_d;
	word_t              dout_q;
	word_t              dout_d;

	logic               snooze;
	logic               proc_go;
	logic               ctrl_go;
	logic               strobe;
	logic               selected;
	lane_mask_t         wr_mask;
	lane_mask_t         lane_we;
	logic  [ADDR_W-1:0] wr_addr;
	logic               read_cyc;

	burst_step_if       step ();

	//////////////////////////////////////////////////////////////////////
	// Write-enable decode, shared by start and burst cycles
	function automatic lane_mask_t write_lanes(
		input logic       gwe_n,
		input logic       gate_n,
		input lane_mask_t lane_n
	);
		lane_mask_t m;
		m = LANES_NONE;
		if (!gwe_n)
			m = LANES_ALL;
		else if (!gate_n)
			m = ~lane_n;
		else
			m = LANES_NONE;
		return m;
	endfunction : write_lanes

	//////////////////////////////////////////////////////////////////////
	// Strobe qualification; only a firm high enters snooze, so a
	// floating pin resolved low by the pad keeps the port awake
	assign snooze   = (SNOOZE_REQ == 1'b1);
	assign proc_go  = !PROC_ADDR_STROBE_N && !MASTER_SELECT_N;
	assign ctrl_go  = !CTRL_ADDR_STROBE_N && !proc_go;
	assign strobe   = proc_go || ctrl_go;
	assign selected = !MASTER_SELECT_N && SELECT_HI
	                  && !SELECT_LO_N;
	assign wr_mask  = write_lanes(GLOBAL_WRITE_N, BYTE_WRITE_GATE_N,
	                              BYTE_LANE_WRITE_N);

	// Order pin is static: any level but a firm low is interleaved
	assign step.interleave = (BURST_ORDER_SEL_N != 1'b0);
	assign step.start_bits = ADDR[BURST_W-1:0];

	burst_sequencer u_seq (
		.clk    (SYS_CLK),
		.arst_n (ARST_N),
		.clk_en (CLK_EN),
		.bus    (step)
	);

	//////////////////////////////////////////////////////////////////////
	// Cycle decode: start, continue, suspend or deselect
	always_comb begin
		mode_d       = mode_q;
		addr_d       = addr_q;
		lane_we      = LANES_NONE;
		wr_addr      = addr_q;
		read_cyc     = 1'b0;
		step.load    = 1'b0;
		step.advance = 1'b0;
		if (snooze) begin
			// Every synchronous input is ignored here
			mode_d = CYC_IDLE;
		end else if (strobe) begin
			if (selected) begin
				addr_d    = ADDR;
				wr_addr   = ADDR;
				step.load = 1'b1;
				// Processor strobe starts a read whatever the write pins
				if (ctrl_go && wr_mask != LANES_NONE) begin
					lane_we = wr_mask;
					mode_d  = CYC_WRITE;
				end else begin
					read_cyc = 1'b1;
					mode_d   = CYC_READ;
				end
			end else begin
				mode_d = CYC_IDLE;
			end
		end else if (mode_q != CYC_IDLE) begin
			// Advance only counts with controller strobe high and processor strobe high or blocked by master enable
			if (!BURST_ADVANCE_N) begin
				step.advance = 1'b1;
				addr_d = {addr_q[ADDR_W-1:BURST_W], step.next_bits};
			end
			wr_addr = addr_d;
			if (wr_mask != LANES_NONE) begin
				lane_we = wr_mask;
				mode_d  = CYC_WRITE;
			end else begin
				read_cyc = 1'b1;
				mode_d   = CYC_READ;
			end
		end
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			mode_q <= CYC_IDLE;
			addr_q <= '0;
		end else if (CLK_EN) begin
			mode_q <= mode_d;
			addr_q <= addr_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Array write, one loop pass per byte lane; storage is not
	// reset, it keeps its contents across snooze. A single process
	// owns the whole array so no element ever has two writers.
	always_ff @(posedge SYS_CLK) begin
		if (CLK_EN) begin
			for (int g = 0; g < LANES; g++) begin
				if (lane_we[g])
					mem[wr_addr][g*LANE_W +: LANE_W] <=
						DQ_IN[g*LANE_W +: LANE_W];
			end
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Read pipeline and output drive hold
	always_comb begin
		rd_pend_d = read_cyc;
		dout_d    = dout_q;
		hold_d    = hold_q;
		if (rd_pend_q && !snooze)
			dout_d = mem[addr_q];
		if (snooze)
			hold_d = HOLD_NONE;
		else if (lane_we != LANES_NONE)
			hold_d = HOLD_NONE;
		else if (rd_pend_q)
			hold_d = DESELECT_HOLD;
		else if (hold_q != HOLD_NONE)
			hold_d = hold_q - HOLD_STEP;
		drive_d = (hold_d != HOLD_NONE);
	end

	always_ff @(posedge SYS_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rd_pend_q <= 1'b0;
			hold_q    <= HOLD_NONE;
			drive_q   <= 1'b0;
			dout_q    <= '0;
		end else if (CLK_EN) begin
			rd_pend_q <= rd_pend_d;
			hold_q    <= hold_d;
			drive_q   <= drive_d;
			dout_q    <= dout_d;
		end
	end

	//////////////////////////////////////////////////////////////////////
	// Outputs. The enable must follow the asynchronous pins at once,
	// so it is the one output gated after the flip-flop; the far side
	// must still turn outputs off before a write after a read.
	assign DQ_OUT = dout_q;
	assign DQ_OE  = drive_q && !OUTPUT_ENABLE_N
	                && !snooze;

endmodule : pipelined_burst_sram_port

// file: core/sram_port_pkg.sv
/*
 * Shared constants and types for the pipelined burst SRAM port.
 * Assumes a single rising-edge clock domain; no register bus.
 */
package sram_port_pkg;

	// Array organisation
	localparam int ADDR_W  = 17;
	localparam int LANES   = 2;
	localparam int LANE_W  = 9;
	localparam int DATA_W  = LANES * LANE_W;
	localparam int BURST_W = 2;

	// Cycles the output stays driven after the last read data
	localparam logic [1:0] DESELECT_HOLD = 2'h2;
	localparam logic [1:0] HOLD_NONE     = 2'h0;
	localparam logic [1:0] HOLD_STEP     = 2'h1;

	// Burst counter values
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;

	// Lane mask values
	localparam logic [LANES-1:0] LANES_NONE = 2'h0;
	localparam logic [LANES-1:0] LANES_ALL  = 2'h3;

	typedef logic [DATA_W-1:0] word_t;
	typedef logic [LANES-1:0]  lane_mask_t;
	typedef logic [BURST_W-1:0] burst_bits_t;

	// What the port is doing between strobes
	typedef enum logic [1:0] {
		CYC_IDLE,
		CYC_READ,
		CYC_WRITE
	} cycle_t;

endpackage : sram_port_pkg

// file: verification/pipelined_burst_sram_port_tb.sv
/* Self-checking bench for the pipelined burst SRAM port.
 * Assumes the checker is bound in and the bus partner model. */
`timescale 1ns/1ps
module pipelined_burst_sram_port_tb;
	import sram_port_pkg::*;
	typedef struct {logic [3:0] w; word_t exp;} row_t;
	// Write-control code {global, gate, lanes} and word read back
	row_t rows [5] = '{'{4'h7, 18'h3FFFF},
		'{4'hA, 18'h001FF}, '{4'h9, 18'h3FE00},
		'{4'hB, 18'h00000}, '{4'hC, 18'h00000}};
	logic SYS_CLK = 0, ARST_N = 0, CLK_EN = 1, MASTER_SELECT_N = 1;
	logic PROC_ADDR_STROBE_N = 1, CTRL_ADDR_STROBE_N = 1, SELECT_HI = 1;
	logic BURST_ADVANCE_N = 1, GLOBAL_WRITE_N = 1, BYTE_WRITE_GATE_N = 1;
	logic SELECT_LO_N = 0, wen = 0, lin = 0, snz = 0;
	logic DQ_OE, OUTPUT_ENABLE_N;
	logic [ADDR_W-1:0] ADDR = '0;
	lane_mask_t BYTE_LANE_WRITE_N = 2'h3;
	word_t DQ_IN, DQ_OUT, wdat = '0;
	tri1 BURST_ORDER_SEL_N;
	tri0 SNOOZE_REQ;
	int fails = 0, check_count = 0;

	// Undriven pins fall back to their pulls
	assign BURST_ORDER_SEL_N = lin ? 1'b0 : 1'bz;
	assign SNOOZE_REQ = snz ? 1'b1 : 1'bz;
	pipelined_burst_sram_port i_dut (.SYS_CLK, .ARST_N, .CLK_EN, .ADDR,
		.DQ_IN, .DQ_OUT, .DQ_OE, .MASTER_SELECT_N, .SELECT_HI,
		.SELECT_LO_N, .PROC_ADDR_STROBE_N, .CTRL_ADDR_STROBE_N,
		.BURST_ADVANCE_N, .GLOBAL_WRITE_N, .BYTE_WRITE_GATE_N,
		.BYTE_LANE_WRITE_N, .OUTPUT_ENABLE_N, .BURST_ORDER_SEL_N,
		.SNOOZE_REQ);
	sram_bus_partner i_bus (.clk(SYS_CLK), .dq_out(DQ_OUT), .dq_oe(DQ_OE),
		.wr_en(wen), .wr_data(wdat), .dq_in(DQ_IN), .oe_n(OUTPUT_ENABLE_N));
	initial forever #25 SYS_CLK = ~SYS_CLK;

	////////////////////////////////////////////////////////////////
	task automatic chk(string name, word_t exp, word_t got);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	// Kinds: 0 idle, 1 proc read, 2 ctrl, 3 advance, 4 deselect, 5 blocked
	task automatic op(int k, logic [16:0] a = '0, word_t d = '0,
		logic [3:0] w = 4'hF);
		@(negedge SYS_CLK);
		MASTER_SELECT_N = (k == 4 || k == 5);
		PROC_ADDR_STROBE_N = !(k == 1 || k == 5);
		CTRL_ADDR_STROBE_N = !(k == 2 || k == 4);
		BURST_ADVANCE_N = !(k == 3 || k == 1);
		{GLOBAL_WRITE_N, BYTE_WRITE_GATE_N, BYTE_LANE_WRITE_N} = w;
		ADDR = a;
		wdat = d;
		wen = k == 2 && (!w[3] || (!w[2] && w[1:0] != 2'h3));
	endtask : op
	// Processor read with global write low; the word lands two edges on
	task automatic rd(logic [16:0] a);
		op(1, a, '0, 4'h7);
		op(0);
		@(negedge SYS_CLK);
	endtask : rd
	task end_of_test;
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (16) @(negedge SYS_CLK);
		chk("reset data", '0, DQ_OUT);
		chk("reset drive", '0, word_t'(DQ_OE));
		ARST_N = 1;
		foreach (rows[i]) begin
			op(2, 17'(16 + i), '0, 4'h7);
			op(2, 17'(16 + i), 18'h3FFFF, rows[i].w);
			rd(17'(16 + i));
			chk("row word", rows[i].exp, DQ_OUT);
		end
		// Both burst orders from every start value
		for (int j = 0; j < 4; j++) op(2, 17'(64 + j), 18'(256 + j), 4'h7);
		for (int m = 0; m < 8; m++) begin
			lin = m[2];
			op(4);
			op(1, 17'(64 + m % 4));
			op(3);
			for (int k = 0; k < 4; k++) begin
				@(negedge SYS_CLK);
				chk("burst word", 18'(256 + (lin ? (m + k) % 4 :
					(m % 4) ^ k)), DQ_OUT);
			end
		end
		// Master enable high must not let the processor strobe reload
		op(2, 17'h20, 18'h12345, 4'h7);
		op(2, 17'h21, 18'h0ABCD, 4'h7);
		rd(17'h20);
		op(5, 17'h21);
		op(0);
		@(negedge SYS_CLK);
		chk("blocked strobe", 18'h12345, DQ_OUT);
		chk("read drive", 18'h1, word_t'(DQ_OE));
		// Snooze once the read is done, then a stalled clock
		snz = 1;
		#1 chk("snooze drive", '0, word_t'(DQ_OE));
		op(2, 17'h20, 18'h3FFFF, 4'h7);
		op(0);
		snz = 0;
		CLK_EN = 0;
		op(2, 17'h20, 18'h3FFFF, 4'h7);
		op(0);
		CLK_EN = 1;
		op(1, 17'h20);
		op(4);
		@(negedge SYS_CLK);
		chk("kept word", 18'h12345, DQ_OUT);
		chk("hold drive", 18'h1, word_t'(DQ_OE));
		repeat (4) op(4);
		chk("released drive", '0, word_t'(DQ_OE));
		end_of_test;
	end
	initial begin
		#1000000;
		fails++;
		end_of_test;
	end
endmodule : pipelined_burst_sram_port_tb

// file: verification/sram_bus_partner.sv
/* Data-bus side of the memory controller facing the port.
 * Assumes the bench tells it when it writes and with what word. */
`timescale 1ns/1ps
module sram_bus_partner (
	input wire logic			clk,
	input wire sram_port_pkg::word_t	dq_out,
	input wire logic			dq_oe,
	input wire logic			wr_en,
	input wire sram_port_pkg::word_t	wr_data,
	output sram_port_pkg::word_t		dq_in,
	output logic				oe_n
);
	import sram_port_pkg::*;
	word_t	last_q = '0;

	////////////////////////////////////////////////////////////////
	// Output enable raised before our own write avoids bus fights
	assign oe_n = wr_en;
	// A released bus never shows stale data: it toggles each cycle
	assign dq_in = wr_en ? wr_data : (dq_oe ? dq_out : ~last_q);
	always @(posedge clk) begin
		last_q <= dq_in;
	end
endmodule : sram_bus_partner

// file: verification/sram_port_asserts.sv
/* Pin-level checker for the pipelined burst SRAM port.
 * Assumes one clock domain; bound into the top module below. */
`timescale 1ns/1ps
module sram_port_asserts
	import sram_port_pkg::*;
#(parameter int ADDR_W = sram_port_pkg::ADDR_W) (
	input wire logic				SYS_CLK,
	input wire logic				ARST_N,
	input wire logic				CLK_EN,
	input wire logic [ADDR_W-1:0]			ADDR,
	input wire sram_port_pkg::word_t		DQ_IN,
	input wire sram_port_pkg::word_t		DQ_OUT,
	input wire logic				DQ_OE,
	input wire logic				MASTER_SELECT_N,
	input wire logic				SELECT_HI,
	input wire logic				SELECT_LO_N,
	input wire logic				PROC_ADDR_STROBE_N,
	input wire logic				CTRL_ADDR_STROBE_N,
	input wire logic				BURST_ADVANCE_N,
	input wire logic				GLOBAL_WRITE_N,
	input wire logic				BYTE_WRITE_GATE_N,
	input wire sram_port_pkg::lane_mask_t		BYTE_LANE_WRITE_N,
	input wire logic				OUTPUT_ENABLE_N,
	input wire logic				BURST_ORDER_SEL_N,
	input wire logic				SNOOZE_REQ
);
	logic	run;
	logic	sel;

	// Snooze or a stalled clock makes an edge count for nothing
	assign run = CLK_EN && !SNOOZE_REQ;
	assign sel = run && !MASTER_SELECT_N && SELECT_HI && !SELECT_LO_N;

	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!ARST_N);

	////////////////////////////////////////////////////////////////
	// Start kinds seen at one edge
	sequence s_rd; sel && !PROC_ADDR_STROBE_N; endsequence
	sequence s_wr;
		sel && PROC_ADDR_STROBE_N && !CTRL_ADDR_STROBE_N && !GLOBAL_WRITE_N;
	endsequence
	sequence s_ds; run && MASTER_SELECT_N && !CTRL_ADDR_STROBE_N; endsequence

	a_oe_gated: assert property (DQ_OE |-> !OUTPUT_ENABLE_N)
		else $error("data driven with output enable high");
	a_snooze_hiz: assert property (SNOOZE_REQ |-> !DQ_OE)
		else $error("data driven during snooze");
	a_write_hiz: assert property (s_wr |=> !DQ_OE)
		else $error("data driven after a write edge");
	a_hold_two: assert property (s_rd ##1 s_ds ##1
		(!OUTPUT_ENABLE_N && !SNOOZE_REQ) |-> DQ_OE)
		else $error("drive dropped one cycle after deselect");
	a_hold_ends: assert property (s_rd ##1 s_ds ##1 s_ds ##1 s_ds
		##1 s_ds |=> !DQ_OE)
		else $error("drive kept too long after deselect");
	a_desel_keep: assert property (s_ds ##1 s_ds |=> $stable(DQ_OUT))
		else $error("read data changed while deselected");
	a_clken_keep: assert property (!CLK_EN |=> $stable(DQ_OUT))
		else $error("read data changed with clock enable low");
	a_write_read: assert property (s_wr ##1
		(s_rd and (ADDR == $past(ADDR))) ##1 run
		|=> DQ_OUT == $past(DQ_IN, 3))
		else $error("read after global write returned other data");
endmodule : sram_port_asserts

bind pipelined_burst_sram_port sram_port_asserts #(.ADDR_W(ADDR_W)) i_chk (
	.SYS_CLK, .ARST_N, .CLK_EN, .ADDR, .DQ_IN, .DQ_OUT, .DQ_OE,
	.MASTER_SELECT_N, .SELECT_HI, .SELECT_LO_N, .PROC_ADDR_STROBE_N,
	.CTRL_ADDR_STROBE_N, .BURST_ADVANCE_N, .GLOBAL_WRITE_N,
	.BYTE_WRITE_GATE_N, .BYTE_LANE_WRITE_N, .OUTPUT_ENABLE_N,
	.BURST_ORDER_SEL_N, .SNOOZE_REQ);
